// [core/sscs_top.sv]
`timescale 1ns/10ps
// Overview of operation
// - Mode bit: 0 synchronous, 1 four-wire bus
// - Select pin open drain or push-pull
// - Data output open drain or push-pull
// - Clock pin open drain or push-pull
// - Select field: port, input, output, output
// - Synchronous mode forces select pin to port
// - Select output acts as input before transfer
// - Bidirectional bit: separate or shared data pin
// - Bidirectional bit ignored in synchronous mode
// - Push-pull data forces data direction bits input
// - Function switch gives pins to other function
// - Reserved bit zero, bits 2:1 read zero
// - Seven internal divisions 1/256..1/4; rate 7 also gives 1/4
// - Master drives clock at selected rate
// - Slave takes clock from clock pin
// - Polarity, phase, mode jointly set sampling
// - Order bit: 1 LSB first, 0 MSB first
// - LSB first loads transmit data bit-reversed
module sscs_top (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write address
   input  wire logic [31:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [31:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Pin inputs, asynchronous
   input  wire sscs_pkg::sscs_pins_t pins_i,
   // Pin drivers
   output sscs_pkg::sscs_pad_t    serial_clock_pin,
   output sscs_pkg::sscs_pad_t    chip_select_pin,
   output sscs_pkg::sscs_pad_t    serial_out_pin,
   output sscs_pkg::sscs_pad_t    serial_in_pin_a,
   output sscs_pkg::sscs_pad_t    serial_in_pin_b
);

   typedef struct packed {
      logic                  awready;
      logic                  wready;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [1:0]            rresp;
      logic [31:0]           rdata;
      logic                  have_aw;
      logic                  have_w;
      logic [7:0]            waddr;
      logic [31:0]           wdata;
      logic [3:0]            wstrb;
      logic [7:0]            serial_mode_two;
      logic [7:0]            pin_mode_select;
      logic [8:0]            control;
      logic [1:0]            port_dir;
      logic [7:0]            rx_data;
      sscs_pkg::sscs_pins_t  sy1;
      sscs_pkg::sscs_pins_t  sy2;
      sscs_pkg::sscs_pins_t  sy3;
      sscs_pkg::sscs_pins_t  filt;
      sscs_pkg::sscs_state_t state;
      logic [7:0]            transfer_shift_reg;
      logic                  hold_bit;
      logic                  out_bit;
      logic                  sck_lvl;
      logic [7:0]            div_cnt;
      logic [4:0]            edge_cnt;
      sscs_pkg::sscs_pad_t   clk_pad;
      sscs_pkg::sscs_pad_t   sel_pad;
      sscs_pkg::sscs_pad_t   so_pad;
      sscs_pkg::sscs_pad_t   si_a_pad;
      sscs_pkg::sscs_pad_t   si_b_pad;
   } sscs_regs_t;

   sscs_regs_t s_r;
   sscs_regs_t s_nxt;

   function automatic logic [7:0] reverse8(input logic [7:0] d);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         r[i] = d[7-i];
      end
      return r;
   endfunction : reverse8

   // Open drain only ever pulls low; high is left to the pull-up
   function automatic sscs_pkg::sscs_pad_t pad(input logic drv, input logic val, input logic od);
      sscs_pkg::sscs_pad_t p;
      p.o  = od ? 1'b0 : val;
      p.oe = drv & (od ? ~val : 1'b1);
      return p;
   endfunction : pad

   // Half period in system clocks; rate 7 clamps to the fastest
   function automatic logic [7:0] half_period(input logic [2:0] rate);
      logic [2:0] r;
      r = (rate > sscs_pkg::RATE_FASTEST) ? sscs_pkg::RATE_FASTEST : rate;
      return sscs_pkg::HALF_SLOWEST >> r;
   endfunction : half_period

   logic       wire_mode;
   logic       bidir;
   logic [1:0] sel_func;
   logic       master;
   logic       phase;
   logic       polarity;
   logic       lsb_first;
   logic       unit_on;
   logic       swap;
   logic       rx_in;
   logic       selected;
   logic       edge_now;
   logic       leading;
   logic       tx_drive;
   logic       tx_on_si;
   logic [7:0] load_val;
   logic [7:0] shifted;
   logic [7:0] rd_val;
   logic       rd_ok;
   logic       wr_ok;

   always_comb begin
      s_nxt = s_r;

      wire_mode = s_r.serial_mode_two[sscs_pkg::MT_WIRE_MODE];
      bidir     = wire_mode & s_r.serial_mode_two[sscs_pkg::MT_BIDIR];
      sel_func  = wire_mode ? s_r.serial_mode_two[sscs_pkg::MT_SEL_FUNC +: 2]
                            : sscs_pkg::SEL_PORT;
      master    = s_r.control[sscs_pkg::CT_MASTER];
      phase     = s_r.control[sscs_pkg::CT_PHASE];
      polarity  = s_r.control[sscs_pkg::CT_POLARITY];
      lsb_first = s_r.control[sscs_pkg::CT_ORDER];
      unit_on   = ~s_r.pin_mode_select[sscs_pkg::PM_FUNC_SW];

      // Four-wire slave swaps the roles of the two data pins
      swap  = wire_mode & ~bidir & ~master;
      rx_in = (wire_mode & (bidir | ~master)) ? s_r.filt.so
            : (s_r.pin_mode_select[sscs_pkg::PM_DATA_ROUTE] ? s_r.filt.si_b : s_r.filt.si_a);
      tx_on_si = swap;

      // Input synchroniser: a change counts once stages two and three agree
      s_nxt.sy1  = pins_i;
      s_nxt.sy2  = s_r.sy1;
      s_nxt.sy3  = s_r.sy2;
      s_nxt.filt = (~(s_r.sy2 ^ s_r.sy3) & s_r.sy3) | ((s_r.sy2 ^ s_r.sy3) & s_r.filt);

      // AXI write channel
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_axi_awvalid && s_r.awready) begin
         s_nxt.have_aw = 1'b1;
         s_nxt.waddr   = s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_r.wready) begin
         s_nxt.have_w = 1'b1;
         s_nxt.wdata  = s_axi_wdata;
         s_nxt.wstrb  = s_axi_wstrb;
      end

      // Register read decode
      rd_ok  = 1'b1;
      rd_val = 8'h00;
      unique case (s_axi_araddr[9:2])
         sscs_pkg::IDX_MODE_TWO:  rd_val = s_r.serial_mode_two;
         sscs_pkg::IDX_PIN_MODE:  rd_val = s_r.pin_mode_select;
         sscs_pkg::IDX_CONTROL:   rd_val = s_r.control[7:0];
         sscs_pkg::IDX_TX_DATA:   rd_val = 8'h00;
         sscs_pkg::IDX_RX_STATUS: rd_val = s_r.rx_data;
         sscs_pkg::IDX_PORT_DIR:  rd_val = {6'h00, s_r.port_dir};
         default:                 rd_ok  = 1'b0;
      endcase
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = rd_ok ? sscs_pkg::RESP_OKAY : sscs_pkg::RESP_SLVERR;
         s_nxt.rdata  = 32'h00000000;
         if (s_axi_araddr[9:2] == sscs_pkg::IDX_CONTROL) begin
            s_nxt.rdata[8:0] = s_r.control;
         end else if (s_axi_araddr[9:2] == sscs_pkg::IDX_RX_STATUS) begin
            s_nxt.rdata[8:0] = {s_r.state == sscs_pkg::ST_RUN, rd_val};
         end else begin
            s_nxt.rdata[7:0] = rd_val;
         end
      end

      // Transfer engine
      load_val = lsb_first ? reverse8(s_r.wdata[7:0]) : s_r.wdata[7:0];
      selected = (sel_func == sscs_pkg::SEL_INPUT) ? ~s_r.filt.cs : 1'b1;
      edge_now = 1'b0;
      leading  = 1'b0;
      if (s_r.state == sscs_pkg::ST_RUN) begin
         if (s_r.edge_cnt == sscs_pkg::EDGES_PER_BYTE) begin
            s_nxt.state = sscs_pkg::ST_IDLE;
         end else if (master) begin
            // Internal divider sets the rate
            if (s_r.div_cnt == half_period(s_r.control[sscs_pkg::CT_RATE +: 3]) - 8'h01) begin
               s_nxt.div_cnt = 8'h00;
               s_nxt.sck_lvl = ~s_r.sck_lvl;
               edge_now      = 1'b1;
               leading       = ~s_r.edge_cnt[0];
            end else begin
               s_nxt.div_cnt = s_r.div_cnt + 8'h01;
            end
         end else if (s_r.filt.sck != s_r.sy3.sck && s_r.sy2.sck == s_r.sy3.sck && selected) begin
            // Slave clocks on agreed pin changes only
            edge_now      = 1'b1;
            leading       = (s_r.sy3.sck != polarity);
         end
      end

      shifted = {s_r.transfer_shift_reg[6:0], phase ? rx_in : s_r.hold_bit};
      if (edge_now) begin
         // Phase 0 samples on the leading edge, phase 1 on the trailing
         if (leading) begin
            if (phase) begin
               s_nxt.out_bit = s_r.transfer_shift_reg[7];
            end else begin
               s_nxt.hold_bit = rx_in;
            end
         end else begin
            s_nxt.transfer_shift_reg = shifted;
            if (!phase) begin
               s_nxt.out_bit = s_r.transfer_shift_reg[6];
            end
         end
         s_nxt.edge_cnt = s_r.edge_cnt + 5'h01;
         if (s_r.edge_cnt == sscs_pkg::EDGES_PER_BYTE - 5'h01) begin
            s_nxt.rx_data = lsb_first ? reverse8(shifted) : shifted;
         end
      end

      // Register write
      wr_ok = 1'b0;
      if (s_nxt.have_aw && s_nxt.have_w && !s_r.bvalid) begin
         wr_ok         = 1'b1;
         s_nxt.have_aw = 1'b0;
         s_nxt.have_w  = 1'b0;
         s_nxt.bvalid  = 1'b1;
         s_nxt.bresp   = sscs_pkg::RESP_OKAY;
         unique case (s_nxt.waddr)
            sscs_pkg::IDX_MODE_TWO: begin
               if (s_nxt.wstrb[0]) begin
                  s_nxt.serial_mode_two = s_nxt.wdata[7:0];
               end
            end
            sscs_pkg::IDX_PIN_MODE: begin
               if (s_nxt.wstrb[0]) begin
                  s_nxt.pin_mode_select = s_nxt.wdata[7:0] & sscs_pkg::PM_WRITE_MASK;
               end
            end
            sscs_pkg::IDX_CONTROL: begin
               if (s_nxt.wstrb[0]) begin
                  s_nxt.control[7:0] = s_nxt.wdata[7:0];
               end
               if (s_nxt.wstrb[1]) begin
                  s_nxt.control[8] = s_nxt.wdata[8];
               end
            end
            sscs_pkg::IDX_TX_DATA: begin
               // Ignored while a byte is in flight or the unit is off
               if (s_nxt.wstrb[0] && s_r.state == sscs_pkg::ST_IDLE && unit_on &&
                   (s_r.control[sscs_pkg::CT_TX_EN] || s_r.control[sscs_pkg::CT_RX_EN])) begin
                  s_nxt.transfer_shift_reg = lsb_first ? reverse8(s_nxt.wdata[7:0])
                                                       : s_nxt.wdata[7:0];
                  s_nxt.out_bit  = lsb_first ? s_nxt.wdata[0] : s_nxt.wdata[7];
                  s_nxt.state    = sscs_pkg::ST_RUN;
                  s_nxt.edge_cnt = 5'h00;
                  s_nxt.div_cnt  = 8'h00;
                  s_nxt.sck_lvl  = polarity;
               end
            end
            sscs_pkg::IDX_PORT_DIR: begin
               if (s_nxt.wstrb[0]) begin
                  s_nxt.port_dir = s_nxt.wdata[1:0];
               end
            end
            sscs_pkg::IDX_RX_STATUS: ;
            default: s_nxt.bresp = sscs_pkg::RESP_SLVERR;
         endcase
      end

      // Push-pull data holds both data direction bits at input
      if (!s_nxt.serial_mode_two[sscs_pkg::MT_DATA_OD]) begin
         s_nxt.port_dir = 2'h0;
      end

      // Idle clock level follows polarity between transfers
      if (s_nxt.state == sscs_pkg::ST_IDLE) begin
         s_nxt.sck_lvl = s_nxt.control[sscs_pkg::CT_POLARITY];
      end

      s_nxt.awready = ~s_nxt.have_aw & ~s_nxt.bvalid;
      s_nxt.wready  = ~s_nxt.have_w & ~s_nxt.bvalid;
      s_nxt.arready = ~s_nxt.rvalid;

      // Pad drivers, registered so every pin comes from a flip-flop
      s_nxt.clk_pad = pad(unit_on & master &
                          s_r.serial_mode_two[sscs_pkg::MT_CLK_SELECT],
                          s_r.sck_lvl, s_r.serial_mode_two[sscs_pkg::MT_CLK_OD]);
      // Select output is only driven while a master transfer runs
      s_nxt.sel_pad = pad(unit_on & master & sel_func[1] & (s_r.state == sscs_pkg::ST_RUN),
                          1'b0, s_r.serial_mode_two[sscs_pkg::MT_SEL_OD]);
      // Shared pin turns around on receive enable
      tx_drive = unit_on & s_r.control[sscs_pkg::CT_TX_EN] &
                 ~(bidir & s_r.control[sscs_pkg::CT_RX_EN]);
      s_nxt.so_pad   = pad(tx_drive & ~tx_on_si, s_r.out_bit,
                           s_r.serial_mode_two[sscs_pkg::MT_DATA_OD]);
      s_nxt.si_a_pad = pad(tx_drive & tx_on_si & ~s_r.pin_mode_select[sscs_pkg::PM_DATA_ROUTE],
                           s_r.out_bit, s_r.serial_mode_two[sscs_pkg::MT_DATA_OD]);
      s_nxt.si_b_pad = pad(tx_drive & tx_on_si & s_r.pin_mode_select[sscs_pkg::PM_DATA_ROUTE],
                           s_r.out_bit, s_r.serial_mode_two[sscs_pkg::MT_DATA_OD]);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r                 <= '0;
         s_r.serial_mode_two <= sscs_pkg::RST_MODE_TWO;
         s_r.pin_mode_select <= sscs_pkg::RST_PIN_MODE;
         s_r.control         <= sscs_pkg::RST_CONTROL;
         s_r.state           <= sscs_pkg::ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready    = s_r.awready;
   assign s_axi_wready     = s_r.wready;
   assign s_axi_bvalid     = s_r.bvalid;
   assign s_axi_bresp      = s_r.bresp;
   assign s_axi_arready    = s_r.arready;
   assign s_axi_rvalid     = s_r.rvalid;
   assign s_axi_rresp      = s_r.rresp;
   assign s_axi_rdata      = s_r.rdata;
   assign serial_clock_pin = s_r.clk_pad;
   assign chip_select_pin  = s_r.sel_pad;
   assign serial_out_pin   = s_r.so_pad;
   assign serial_in_pin_a  = s_r.si_a_pad;
   assign serial_in_pin_b  = s_r.si_b_pad;

endmodule : sscs_top

// [core/sscs_pkg.sv]
package sscs_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_MODE_TWO  = 8'hbd;
   localparam logic [7:0] IDX_PIN_MODE  = 8'hf8;
   localparam logic [7:0] IDX_CONTROL   = 8'hc0;
   localparam logic [7:0] IDX_TX_DATA   = 8'hc1;
   localparam logic [7:0] IDX_RX_STATUS = 8'hc2;
   localparam logic [7:0] IDX_PORT_DIR  = 8'hc3;

   // Reset values
   localparam logic [7:0] RST_MODE_TWO = 8'h00;
   localparam logic [7:0] RST_PIN_MODE = 8'h00;
   localparam logic [8:0] RST_CONTROL  = 9'h000;

   // serial_mode_two fields
   localparam int MT_WIRE_MODE  = 0;
   localparam int MT_SEL_OD     = 1;
   localparam int MT_DATA_OD    = 2;
   localparam int MT_CLK_OD     = 3;
   localparam int MT_SEL_FUNC   = 4;
   localparam int MT_CLK_SELECT = 6;
   localparam int MT_BIDIR      = 7;

   // pin_mode_select fields
   localparam int PM_DATA_ROUTE = 3;
   localparam int PM_FUNC_SW    = 7;
   localparam logic [7:0] PM_WRITE_MASK = 8'hf9;

   // control fields
   localparam int CT_RATE     = 0;
   localparam int CT_MASTER   = 3;
   localparam int CT_PHASE    = 4;
   localparam int CT_POLARITY = 5;
   localparam int CT_ORDER    = 6;
   localparam int CT_TX_EN    = 7;
   localparam int CT_RX_EN    = 8;

   // Chip select pin functions
   localparam logic [1:0] SEL_PORT  = 2'h0;
   localparam logic [1:0] SEL_INPUT = 2'h1;

   // Rates and transfer length
   localparam logic [2:0] RATE_FASTEST  = 3'h6;
   localparam logic [7:0] HALF_SLOWEST  = 8'h80;
   localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } sscs_state_t;

   typedef struct packed {
      logic o;
      logic oe;
   } sscs_pad_t;

   // Sampled inputs: {si_b, si_a, so, cs, sck}
   typedef struct packed {
      logic si_b;
      logic si_a;
      logic so;
      logic cs;
      logic sck;
   } sscs_pins_t;

endpackage : sscs_pkg

// [tb/sscs_top_properties.sv]
`timescale 1ns/10ps
module sscs_top_properties (
   // Clock and reset
   input wire logic                aclk,
   input wire logic                aresetn,
   // Register bus
   input wire logic                s_axi_awvalid,
   input wire logic                s_axi_awready,
   input wire logic                s_axi_wvalid,
   input wire logic                s_axi_wready,
   input wire logic [1:0]          s_axi_bresp,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_bready,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic [31:0]         s_axi_rdata,
   input wire logic [1:0]          s_axi_rresp,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_rready,
   // Pads
   input wire sscs_pkg::sscs_pad_t serial_clock_pin,
   input wire sscs_pkg::sscs_pad_t chip_select_pin,
   input wire sscs_pkg::sscs_pad_t serial_in_pin_a,
   input wire sscs_pkg::sscs_pad_t serial_in_pin_b
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Released clock pad floats to the pull-up
   wire logic sck_lvl = serial_clock_pin.oe ? serial_clock_pin.o : 1'b1;

   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   AST_B_AFTER_WRITE: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid) else $error("write response late");
   AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_W_READY_LOW: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_AR_READY_LOW: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0)
      else $error("unassigned read bits not zero");
   AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == sscs_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("refused read returned data");
   AST_SELECT_LOW: assert property (chip_select_pin.oe |-> !chip_select_pin.o)
      else $error("select driven inactive");
   AST_ONE_IN_PIN: assert property (!(serial_in_pin_a.oe && serial_in_pin_b.oe))
      else $error("both input pins driven");
   AST_CLK_HALF: assert property ($changed(sck_lvl) |=> $stable(sck_lvl))
      else $error("clock faster than a quarter");
endmodule : sscs_top_properties

bind sscs_top sscs_top_properties u_props (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .serial_clock_pin(serial_clock_pin),
   .chip_select_pin(chip_select_pin), .serial_in_pin_a(serial_in_pin_a), .serial_in_pin_b(serial_in_pin_b)
);

// [tb/sscs_peer_model.sv]
`timescale 1ns/10ps
module sscs_peer_model (
   // Line levels
   input  wire logic       sck_lvl,
   input  wire logic       cs_n_lvl,
   input  wire logic       mosi,
   // Set-up
   input  wire logic       cpol,
   input  wire logic       cpha,
   input  wire logic       free,
   input  wire logic [7:0] tx_byte,
   // Data
   output logic            miso,
   output logic [7:0]      rx_byte
);
   logic [7:0] sh = 8'h00;
   logic       lead;
   initial miso = 1'b1;
   initial rx_byte = 8'h00;
   // Phase 0 needs the first bit before the first edge
   always @(negedge cs_n_lvl or tx_byte) begin
      sh = tx_byte;
      if (!cpha) miso <= tx_byte[7];
   end
   // Released line must not keep the last bit
   always @(posedge cs_n_lvl) miso <= ~miso;
   always @(sck_lvl) begin
      if (!cs_n_lvl || free) begin
         lead = (sck_lvl != cpol);
         if (lead ^ cpha) begin
            rx_byte = {rx_byte[6:0], mosi};
         end else if (cpha) begin
            miso <= sh[7];
            sh = sh << 1;
         end else begin
            sh = sh << 1;
            miso <= sh[7];
         end
      end
   end
endmodule : sscs_peer_model

// [tb/sync_serial_chip_select_config_tb_top.sv]
`timescale 1ns/10ps
module sync_serial_chip_select_config_tb_top;
   // Clock, reset, register bus
   logic                 aclk = 1'b0, aresetn = 1'b0;
   logic [31:0]          s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd_val;
   logic [3:0]           s_axi_wstrb = 4'hf;
   logic                 s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic                 s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]           s_axi_bresp, s_axi_rresp, rd_resp;
   // Pads and line levels
   sscs_pkg::sscs_pad_t  sck_p, cs_p, so_p, sia_p, sib_p;
   sscs_pkg::sscs_pins_t pins;
   logic                 sck_lvl, cs_lvl, so_lvl, miso, cs_seen = 1'b0;
   logic                 route = 1'b0, pol = 1'b0, pha = 1'b0, free_run = 1'b0;
   logic [7:0]           peer_tx = 8'h00, peer_rx, d, p;
   time                  t_a, t_b;
   int                   n_edges = 0, mismatches = 0, num_checks = 0;

   always #12.5 aclk = ~aclk;
   assign sck_lvl = sck_p.oe ? sck_p.o : 1'b1;
   assign cs_lvl  = cs_p.oe ? cs_p.o : 1'b1;
   assign so_lvl  = so_p.oe ? so_p.o : 1'b1;
   // Unrouted pin carries the inverse, so a wrong route shows
   assign pins = '{si_b: route ? miso : ~miso, si_a: route ? ~miso : miso, so: so_lvl, cs: cs_lvl, sck: sck_lvl};

   sscs_top dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pins_i(pins),
      .serial_clock_pin(sck_p), .chip_select_pin(cs_p), .serial_out_pin(so_p),
      .serial_in_pin_a(sia_p), .serial_in_pin_b(sib_p));

   sscs_peer_model peer (.sck_lvl(sck_lvl), .cs_n_lvl(cs_lvl), .mosi(so_lvl), .cpol(pol), .cpha(pha),
      .free(free_run), .tx_byte(peer_tx), .miso(miso), .rx_byte(peer_rx));

   always @(sck_lvl) begin
      if (!cs_lvl || free_run) begin
         n_edges = n_edges + 1;
         if (n_edges == 1) t_a = $time;
         if (n_edges == 2) t_b = $time;
      end
   end
   always @(negedge cs_lvl) cs_seen = 1'b1;

   task automatic wrap_up();
      if (mismatches == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic give_up();
      mismatches++;
      wrap_up();
   endtask : give_up

   task automatic wr(input logic [7:0] idx, input logic [31:0] v, input logic [1:0] resp = sscs_pkg::RESP_OKAY);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= {22'h0, idx, 2'b00};
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (n > 200) give_up();
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("write resp", {30'h0, resp}, {30'h0, s_axi_bresp});
   endtask : wr

   task automatic rd(input logic [7:0] idx);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= {22'h0, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (n > 200) give_up();
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      rd_val = s_axi_rdata;
      rd_resp = s_axi_rresp;
   endtask : rd

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] v, input logic [1:0] resp = sscs_pkg::RESP_OKAY);
      rd(idx);
      chk($sformatf("reg %h", idx), v, rd_val);
      chk("read resp", {30'h0, resp}, {30'h0, rd_resp});
   endtask : rd_chk

   task automatic wait_idle(input int min);
      int k;
      k = 0;
      do begin
         rd(sscs_pkg::IDX_RX_STATUS);
         k++;
      end while ((rd_val[8] !== 1'b0 || n_edges < min) && k < 3000);
      if (k >= 3000) give_up();
   endtask : wait_idle

   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int k = 0; k < 8; k++) rev8[k] = v[7 - k];
   endfunction : rev8

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd_chk(sscs_pkg::IDX_MODE_TWO, 32'h0);
      rd_chk(sscs_pkg::IDX_PIN_MODE, 32'h0);
      rd_chk(sscs_pkg::IDX_CONTROL, 32'h0);
      rd_chk(8'h00, 32'h0, sscs_pkg::RESP_SLVERR);
      wr(8'h00, 32'hff, sscs_pkg::RESP_SLVERR);
      wr(sscs_pkg::IDX_PIN_MODE, 32'hfe);
      rd_chk(sscs_pkg::IDX_PIN_MODE, 32'hf8);
      wr(sscs_pkg::IDX_MODE_TWO, 32'hfb);
      wr(sscs_pkg::IDX_PORT_DIR, 32'h3);
      rd_chk(sscs_pkg::IDX_PORT_DIR, 32'h0);
      wr(sscs_pkg::IDX_MODE_TWO, 32'hff);
      rd_chk(sscs_pkg::IDX_MODE_TWO, 32'hff);
      wr(sscs_pkg::IDX_PORT_DIR, 32'h3);
      rd_chk(sscs_pkg::IDX_PORT_DIR, 32'h3);
      for (int i = 0; i < 8; i++) begin
         d = 8'h4b + 8'(i);
         p = 8'hd2 - 8'(i);
         route = (i == 5);
         pol = i[0];
         pha = i[1];
         peer_tx = p;
         wr(sscs_pkg::IDX_CONTROL, 32'h0);
         wr(sscs_pkg::IDX_PIN_MODE, {28'h0, route, 3'h0});
         wr(sscs_pkg::IDX_MODE_TWO, i[0] ? 32'h6f : 32'h61);
         wr(sscs_pkg::IDX_CONTROL, {23'h0, 2'b11, i[2], i[0], i[1], 1'b1, 3'(i % 5)});
         chk("select before start", 32'h1, {31'h0, cs_lvl});
         n_edges = 0;
         cs_seen = 1'b0;
         wr(sscs_pkg::IDX_TX_DATA, {24'h0, d});
         wait_idle(16);
         chk("edges", 32'd16, n_edges);
         chk("half period", (32'd128 >> (i % 5)) * 32'd25, 32'(t_b - t_a));
         chk("peer rx", {24'h0, i[2] ? rev8(d) : d}, {24'h0, peer_rx});
         chk("unit rx", {24'h0, i[2] ? rev8(p) : p}, {24'h0, rd_val[7:0]});
         chk("idle clock", {31'h0, i[0]}, {31'h0, sck_lvl});
         chk("select used", 32'h1, {31'h0, cs_seen});
      end
      wr(sscs_pkg::IDX_CONTROL, 32'h0);
      wr(sscs_pkg::IDX_MODE_TWO, 32'he0);
      wr(sscs_pkg::IDX_CONTROL, 32'h18a);
      pol = 1'b0;
      pha = 1'b0;
      d = 8'h5a;
      p = 8'hc6;
      peer_tx = p;
      n_edges = 0;
      cs_seen = 1'b0;
      wr(sscs_pkg::IDX_TX_DATA, {24'h0, d});
      free_run = 1'b1;
      wait_idle(16);
      chk("sync select", 32'h0, {31'h0, cs_seen});
      chk("sync peer rx", {24'h0, d}, {24'h0, peer_rx});
      chk("sync unit rx", {24'h0, p}, {24'h0, rd_val[7:0]});
      for (int r = 5; r < 8; r++) begin
         wr(sscs_pkg::IDX_CONTROL, 32'h108 | r);
         n_edges = 0;
         wr(sscs_pkg::IDX_TX_DATA, 32'h0);
         wait_idle(16);
         chk("fast half", r > 6 ? 32'h32 : 32'hc80 >> r, 32'(t_b - t_a));
      end
      wr(sscs_pkg::IDX_PIN_MODE, 32'h80);
      wr(sscs_pkg::IDX_TX_DATA, 32'h33);
      n_edges = 0;
      wait_idle(0);
      chk("switched edges", 32'h0, n_edges);
      chk("clock released", 32'h0, {31'h0, sck_p.oe});
      wrap_up();
   end
endmodule : sync_serial_chip_select_config_tb_top
